// [cpc_counter.sv]
/*
 * configurable pulse counter with an axi4-lite register slave.
 * assumes pins count_src, count_gate and count_dir arrive from outside
 * the aclk domain; the internal source is the enabled aclk itself.
 */
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
// Overview of operation
// - count rising or falling source edges
// - 32-bit variant counts full 32 bits
// - 24-bit variant wraps at 2^24-1
// - 16-bit variant counts up or down
// - step one per counted edge, configured direction
// - direction may come from external pin in 32- and 24-bit variants
// - fixed variant counts rising edges downward
// - fixed variant gates on high level only
// - toggle or single pulse at terminal count
// - pulse lasts until the next counted edge; the last pulse of a single run lasts one clock
// - period is phase one plus two
// - positive idles low, negative idles high
// - phase one until rise, phase two until fall
// - train repeats phases without stopping
// - fixed variant single pulse is negative
// - fixed variant trains are positive
// - fixed train splits load in halves
// - odd load makes phase one longer
// - no gate: software start; optional external source
// - preload count, read without disturbing
// - terminal count zero down, maximum up
`include "cpc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpc_counter
    import cpc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // counter pins
    input  wire logic        count_src,
    input  wire logic        count_gate,
    input  wire logic        count_dir,
    output var  logic        wave_out
);

    cpc_cfg_t    cfg;
    cpc_state_t  state;
    cpc_pins_t   sync1;
    cpc_pins_t   sync2;
    cpc_pins_t   sync3;
    logic [31:0] count;
    logic [31:0] preload;
    logic [31:0] phase1_len;
    logic [31:0] phase2_len;
    logic        load_req;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wave_level;
    logic        pulse_now;
    logic        tc_seen;

    function automatic logic [31:0] cpc_mask(input cpc_variant_t v);
        case (v)
            CPC_VAR_W32: cpc_mask = 32'hFFFF_FFFF;
            CPC_VAR_W24: cpc_mask = 32'h00FF_FFFF;
            default:     cpc_mask = 32'h0000_FFFF;
        endcase
    endfunction

    function automatic logic [31:0] cpc_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        cpc_merge = r;
    endfunction

    // two-stage pin synchroniser, third stage for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else if (clk_en) begin
            sync1 <= '{src: count_src, gate: count_gate, dir: count_dir};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    logic fixed;
    logic src_rise;
    logic src_fall;
    logic edge_hit;
    logic gate_ok;
    logic go_down;
    logic [31:0] mask;
    logic [31:0] tc_value;
    logic [31:0] next_count;
    logic at_tc;

    always_comb begin
        fixed    = (cfg.variant == CPC_VAR_FIXED);
        mask     = cpc_mask(cfg.variant);
        src_rise = sync2.src & ~sync3.src;
        src_fall = ~sync2.src & sync3.src;
        if (!cfg.ext_src) begin
            edge_hit = 1'b1;
        end else if (fixed || !cfg.fall_edge) begin
            edge_hit = src_rise;
        end else begin
            edge_hit = src_fall;
        end
        gate_ok = !cfg.gated || sync2.gate;
        if (fixed) begin
            go_down = 1'b1;
        end else if (cfg.ext_dir && cfg.variant != CPC_VAR_W16) begin
            go_down = ~sync2.dir;
        end else begin
            go_down = cfg.down;
        end
        tc_value   = go_down ? 32'h0000_0000 : mask;
        at_tc      = (count == tc_value);
        next_count = (go_down ? count - 32'h0000_0001 : count + 32'h0000_0001) & mask;
    end

    // configuration and preload registers
    logic wr_fire;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg        <= cpc_cfg_t'(11'h000);
            preload    <= 32'h0000_0000;
            phase1_len <= 32'h0000_0001;
            phase2_len <= 32'h0000_0001;
            load_req   <= 1'b0;
        end else if (clk_en) begin
            load_req <= 1'b0;
            if (state == CPC_ST_DONE && cfg.start) begin
                cfg.start <= 1'b0;
            end
            if (wr_fire) begin
                if (aw_addr == `CPC_CTRL_OFF) begin
                    if (w_strb[0]) begin
                        cfg.start     <= w_data[`CPC_CTRL_START];
                        cfg.fall_edge <= w_data[`CPC_CTRL_FALL];
                        cfg.down      <= w_data[`CPC_CTRL_DOWN];
                        cfg.ext_dir   <= w_data[`CPC_CTRL_EXTDIR];
                        cfg.pulsed    <= w_data[`CPC_CTRL_PULSED];
                        cfg.neg_pol   <= w_data[`CPC_CTRL_NEG];
                        cfg.train     <= w_data[`CPC_CTRL_TRAIN];
                        cfg.gated     <= w_data[`CPC_CTRL_GATED];
                    end
                    if (w_strb[1]) begin
                        cfg.ext_src <= w_data[`CPC_CTRL_EXTSRC];
                        cfg.variant <= cpc_variant_t'(w_data[`CPC_CTRL_VAR_HI:`CPC_CTRL_VAR_LO]);
                        load_req    <= w_data[`CPC_CTRL_LOAD];
                    end
                end else if (aw_addr == `CPC_PRELOAD_OFF) begin
                    preload <= cpc_merge(preload, w_data, w_strb);
                end else if (aw_addr == `CPC_PHASE1_OFF) begin
                    phase1_len <= cpc_merge(phase1_len, w_data, w_strb);
                end else if (aw_addr == `CPC_PHASE2_OFF) begin
                    phase2_len <= cpc_merge(phase2_len, w_data, w_strb);
                end
            end
        end
    end

    // phase lengths for the counter; fixed train halves the preload
    logic [31:0] len1;
    logic [31:0] len2;
    always_comb begin
        if (fixed && cfg.train) begin
            len2 = {1'b0, preload[31:1]} & mask;
            len1 = ({1'b0, preload[31:1]} + {31'h0, preload[0]}) & mask;
        end else begin
            len1 = phase1_len & mask;
            len2 = phase2_len & mask;
        end
    end

    logic [31:0] reload;
    always_comb begin
        reload = go_down ? (state == CPC_ST_PHASE1 ? len2 : len1)
                         : ((mask - (state == CPC_ST_PHASE1 ? len2 : len1)) & mask);
    end

    // count register and phase sequencer
    logic step;
    assign step = edge_hit && gate_ok && (state == CPC_ST_PHASE1 || state == CPC_ST_PHASE2);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count   <= `CPC_COUNT_RESET;
            state   <= CPC_ST_IDLE;
            tc_seen <= 1'b0;
        end else if (clk_en) begin
            tc_seen <= 1'b0;
            if (load_req && state != CPC_ST_PHASE1 && state != CPC_ST_PHASE2) begin
                count <= preload & mask;
            end
            case (state)
                CPC_ST_IDLE: begin
                    if (cfg.start) begin
                        state <= CPC_ST_PHASE1;
                        count <= go_down ? len1 : (mask - len1) & mask;
                    end
                end
                CPC_ST_PHASE1: begin
                    if (!cfg.start) begin
                        state <= CPC_ST_IDLE;
                    end else if (step) begin
                        if (at_tc) begin
                            tc_seen <= 1'b1;
                            state   <= CPC_ST_PHASE2;
                            count   <= reload;
                        end else begin
                            count <= next_count;
                        end
                    end
                end
                CPC_ST_PHASE2: begin
                    if (!cfg.start) begin
                        state <= CPC_ST_IDLE;
                    end else if (step) begin
                        if (at_tc) begin
                            tc_seen <= 1'b1;
                            state   <= cfg.train ? CPC_ST_PHASE1 : CPC_ST_DONE;
                            count   <= reload;
                        end else begin
                            count <= next_count;
                        end
                    end
                end
                CPC_ST_DONE: begin
                    state <= CPC_ST_IDLE;
                end
                default: begin
                    state <= CPC_ST_IDLE;
                end
            endcase
        end
    end

    // waveform generation
    logic idle_level;
    always_comb begin
        if (fixed) begin
            idle_level = !cfg.train;
        end else begin
            idle_level = cfg.neg_pol;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_level <= 1'b0;
            pulse_now  <= 1'b0;
        end else if (clk_en) begin
            if (state == CPC_ST_IDLE) begin
                wave_level <= 1'b0;
                pulse_now  <= 1'b0;
            end else if (cfg.pulsed && !fixed) begin
                wave_level <= 1'b0;
                if (tc_seen) begin
                    pulse_now <= 1'b1;
                end else if (edge_hit && gate_ok) begin
                    pulse_now <= 1'b0;
                end
            end else if (tc_seen) begin
                wave_level <= ~wave_level;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_out <= 1'b0;
        end else if (clk_en) begin
            wave_out <= idle_level ^ wave_level ^ pulse_now;
        end
    end

    // axi4-lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CPC_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == `CPC_CTRL_OFF || aw_addr == `CPC_PRELOAD_OFF ||
                                 aw_addr == `CPC_PHASE1_OFF || aw_addr == `CPC_PHASE2_OFF)
                                ? `CPC_OKAY : `CPC_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // axi4-lite read channel; reads never disturb the count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `CPC_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (!s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= s_axi_arvalid;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `CPC_OKAY;
                if (s_axi_araddr == `CPC_CTRL_OFF) begin
                    s_axi_rdata <= {21'h0, cfg.variant, cfg.ext_src, cfg.gated, cfg.train, cfg.neg_pol,
                                    cfg.pulsed, cfg.ext_dir, cfg.down, cfg.fall_edge, cfg.start};
                end else if (s_axi_araddr == `CPC_PRELOAD_OFF) begin
                    s_axi_rdata <= preload;
                end else if (s_axi_araddr == `CPC_PHASE1_OFF) begin
                    s_axi_rdata <= phase1_len;
                end else if (s_axi_araddr == `CPC_PHASE2_OFF) begin
                    s_axi_rdata <= phase2_len;
                end else if (s_axi_araddr == `CPC_COUNT_OFF) begin
                    s_axi_rdata <= count;
                end else if (s_axi_araddr == `CPC_STATUS_OFF) begin
                    s_axi_rdata <= {28'h0, wave_out, go_down, state};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `CPC_SLVERR;
                end
            end
        end
    end

endmodule
`default_nettype wire

// [cpc_counter_sva.sv]
/*
 * port assertions for the configurable pulse counter.
 * assumes binding to cpc_counter; sees its ports only.
 */
`include "cpc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpc_counter_sva (
    // clock, reset, enable
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    // write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // waveform
    input wire logic        wave_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rst_idle_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn && clk_en |=> !s_axi_bvalid && !s_axi_rvalid && !wave_out)
        else $error("outputs not idle after reset");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read address ready held");
    r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `CPC_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("refused read returns data");
    freeze_a: assert property (!clk_en |=> $stable(wave_out) && $stable(s_axi_bvalid))
        else $error("state moved while disabled");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rresp == `CPC_SLVERR);
    cover property ($rose(wave_out));
endmodule

bind cpc_counter cpc_counter_sva cpc_counter_sva_inst (.*);
`default_nettype wire

// [cpc_ext_source.sv]
/*
 * external circuit: makes the count source, watches the waveform.
 * assumes the same clock as the counter.
 */
`timescale 1ns/1ps
`default_nettype none
module cpc_ext_source (
    // clock
    input  wire logic       aclk,
    // source control
    input  wire logic       run,
    input  wire logic [7:0] half,
    // pins
    input  wire logic       wave,
    output var  logic       src,
    // measurements
    output var  int         hi_len,
    output var  int         per,
    output var  int         rises
);
    int   cnt;
    int   hi;
    int   since;
    logic wave_q;

    initial begin
        src = 1'b0; cnt = 0; hi = 0; since = 0;
        wave_q = 1'b0; hi_len = 0; per = 0; rises = 0;
    end

    // source stands still when not running
    always @(posedge aclk) begin
        if (run && cnt + 1 >= int'(half)) begin
            cnt <= 0;
            src <= ~src;
        end else begin
            cnt <= run ? cnt + 1 : 0;
        end
    end

    // high width and rise to rise period in clocks
    always @(posedge aclk) begin
        wave_q <= wave;
        since  <= since + 1;
        hi     <= (wave === 1'b1) ? hi + 1 : 0;
        if (wave === 1'b1 && wave_q === 1'b0) begin
            rises <= rises + 1;
            per   <= since;
            since <= 1;
        end
        if (wave === 1'b0 && wave_q === 1'b1) begin
            hi_len <= hi;
        end
    end
endmodule
`default_nettype wire

// [cpc_pkg.sv]
/*
 * types of the configurable pulse counter.
 * assumes nothing of its surroundings.
 */
package cpc_pkg;
    typedef enum logic [1:0] {
        CPC_VAR_W32   = 2'b00,
        CPC_VAR_W24   = 2'b01,
        CPC_VAR_W16   = 2'b10,
        CPC_VAR_FIXED = 2'b11
    } cpc_variant_t;

    typedef enum logic [1:0] {
        CPC_ST_IDLE  = 2'b00,
        CPC_ST_PHASE1 = 2'b01,
        CPC_ST_PHASE2 = 2'b10,
        CPC_ST_DONE  = 2'b11
    } cpc_state_t;

    typedef struct packed {
        logic         start;
        logic         fall_edge;
        logic         down;
        logic         ext_dir;
        logic         pulsed;
        logic         neg_pol;
        logic         train;
        logic         gated;
        logic         ext_src;
        cpc_variant_t variant;
    } cpc_cfg_t;

    typedef struct packed {
        logic src;
        logic gate;
        logic dir;
    } cpc_pins_t;
endpackage

// [cpc_regs.svh]
/*
 * register offsets, field positions, reset values and response codes
 * of the configurable pulse counter.
 * assumes inclusion by bare name; holds definitions only.
 */
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH

// byte offsets
`define CPC_CTRL_OFF     8'h00
`define CPC_PRELOAD_OFF  8'h04
`define CPC_PHASE1_OFF   8'h08
`define CPC_PHASE2_OFF   8'h0C
`define CPC_COUNT_OFF    8'h10
`define CPC_STATUS_OFF   8'h14

// control fields
`define CPC_CTRL_START   0
`define CPC_CTRL_FALL    1
`define CPC_CTRL_DOWN    2
`define CPC_CTRL_EXTDIR  3
`define CPC_CTRL_PULSED  4
`define CPC_CTRL_NEG     5
`define CPC_CTRL_TRAIN   6
`define CPC_CTRL_GATED   7
`define CPC_CTRL_EXTSRC  8
`define CPC_CTRL_VAR_LO  9
`define CPC_CTRL_VAR_HI  10
`define CPC_CTRL_LOAD    11

`define CPC_CTRL_RESET   32'h0000_0000
`define CPC_COUNT_RESET  32'h0000_0000
`define CPC_SLVERR       2'b10
`define CPC_OKAY         2'b00

`endif

// [test_configurable_pulse_counter.sv]
/*
 * self-checking bench for the configurable pulse counter.
 * assumes cpc_counter, cpc_ext_source and the register header.
 */
`include "cpc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_configurable_pulse_counter;
    logic        aclk, aresetn, clk_en, src_run;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, src_half;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        count_src, count_gate, count_dir, wave_out;
    int          hi_len, per, rises, error_cnt, n_tests;

    cpc_counter cpc_counter_inst (.*);
    cpc_ext_source cpc_ext_source_inst (
        .aclk(aclk), .run(src_run), .half(src_half), .wave(wave_out), .src(count_src),
        .hi_len(hi_len), .per(per), .rises(rises)
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task cfg(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, `CPC_OKAY}, "write response");
    endtask

    task wait_done;
        logic [31:0] st;
        logic [1:0]  r;
        for (int i = 0; i < 400; i++) begin
            rd(`CPC_CTRL_OFF, st, r);
            if (st[`CPC_CTRL_START] === 1'b0) break;
        end
        repeat (4) @(posedge aclk);
    endtask

    task pulse(input logic [31:0] ctrl, input int w, input bit one);
        int r0;
        r0 = rises;
        cfg(`CPC_CTRL_OFF, ctrl);
        wait_done;
        chk(hi_len, w, "pulse width");
        if (one) chk(rises - r0, 1, "pulse count");
    endtask

    task t_reg;
        logic [31:0] d;
        logic [1:0]  r;
        logic [31:0] ctl[4] = '{32'h0000_0800, 32'h0000_0A00, 32'h0000_0C00, 32'h0000_0E00};
        logic [31:0] msk[4] = '{32'hFFFF_FFFF, 32'h00FF_FFFF, 32'h0000_FFFF, 32'h0000_FFFF};
        chk({31'h0, wave_out}, 0, "idle wave");
        rd(`CPC_COUNT_OFF, d, r);
        chk(d, `CPC_COUNT_RESET, "count reset");
        rd(`CPC_CTRL_OFF, d, r);
        chk(d, `CPC_CTRL_RESET, "ctrl reset");
        wr(8'h18, 32'h0000_0001, r);
        chk({30'h0, r}, {30'h0, `CPC_SLVERR}, "unmapped write");
        wr(`CPC_COUNT_OFF, 32'h0000_0001, r);
        chk({30'h0, r}, {30'h0, `CPC_SLVERR}, "count write");
        rd(8'h18, d, r);
        chk({30'h0, r}, {30'h0, `CPC_SLVERR}, "unmapped read");
        cfg(`CPC_PRELOAD_OFF, 32'hFFFF_FFFF);
        for (int i = 0; i < 4; i++) begin
            cfg(`CPC_CTRL_OFF, ctl[i]);
            rd(`CPC_COUNT_OFF, d, r);
            chk(d, msk[i], "preload width");
            rd(`CPC_COUNT_OFF, d, r);
            chk(d, msk[i], "reread count");
        end
        $display("test registers done");
    endtask

    task t_single;
        cfg(`CPC_CTRL_OFF, 32'h0000_0000);
        cfg(`CPC_PHASE1_OFF, 32'h0000_0003);
        cfg(`CPC_PHASE2_OFF, 32'h0000_0004);
        pulse(32'h0000_0005, 5, 1);
        pulse(32'h0000_0001, 5, 1);
        pulse(32'h0000_0015, 1, 0);
        cfg(`CPC_CTRL_OFF, 32'h0000_0020);
        repeat (4) @(posedge aclk);
        chk({31'h0, wave_out}, 1, "negative idle");
        $display("test single done");
    endtask

    task t_train;
        int r0;
        cfg(`CPC_CTRL_OFF, 32'h0000_0000);
        r0 = rises;
        cfg(`CPC_CTRL_OFF, 32'h0000_0045);
        repeat (60) @(posedge aclk);
        chk(per, 9, "train period");
        chk(hi_len, 5, "train high");
        chk(rises - r0 > 4, 1, "train repeats");
        clk_en <= 1'b0;
        repeat (20) @(posedge aclk);
        clk_en <= 1'b1;
        repeat (40) @(posedge aclk);
        cfg(`CPC_CTRL_OFF, 32'h0000_0000);
        repeat (4) @(posedge aclk);
        chk({31'h0, wave_out}, 0, "stop idles");
        $display("test train done");
    endtask

    task t_fixed;
        logic [31:0] ld[2] = '{32'h0000_0007, 32'h0000_0008};
        int          hw[2] = '{4, 5};
        int          pw[2] = '{9, 10};
        for (int i = 0; i < 2; i++) begin
            cfg(`CPC_CTRL_OFF, 32'h0000_0000);
            cfg(`CPC_PRELOAD_OFF, ld[i]);
            cfg(`CPC_CTRL_OFF, 32'h0000_0641);
            repeat (60) @(posedge aclk);
            chk(hi_len, hw[i], "fixed train high");
            chk(per, pw[i], "fixed train period");
        end
        cfg(`CPC_CTRL_OFF, 32'h0000_0000);
        cfg(`CPC_PRELOAD_OFF, 32'h0000_0014);
        cfg(`CPC_CTRL_OFF, 32'h0000_0601);
        repeat (5) @(posedge aclk);
        chk({31'h0, wave_out}, 1, "fixed delay high");
        cfg(`CPC_CTRL_OFF, 32'h0000_0000);
        $display("test fixed done");
    endtask

    task t_ext;
        logic [31:0] st;
        logic [1:0]  r;
        logic [31:0] ctl[3] = '{32'h0000_0187, 32'h0000_0189, 32'h0000_0189};
        cfg(`CPC_PHASE1_OFF, 32'h0000_0001);
        cfg(`CPC_PHASE2_OFF, 32'h0000_0002);
        src_run <= 1'b1;
        cfg(`CPC_CTRL_OFF, 32'h0000_0185);
        repeat (100) @(posedge aclk);
        rd(`CPC_STATUS_OFF, st, r);
        chk({30'h0, st[1:0]}, 1, "gate holds");
        count_gate <= 1'b1;
        wait_done;
        chk(hi_len, 18, "gated width");
        for (int i = 0; i < 3; i++) begin
            count_dir <= i[0];
            pulse(ctl[i], 18, 1);
        end
        src_run <= 1'b0;
        $display("test external done");
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test;
    end

    initial begin
        error_cnt = 0; n_tests = 0; aresetn = 1'b0; clk_en = 1'b1;
        s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0000_0000; s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0; count_gate = 1'b0; count_dir = 1'b0; src_run = 1'b0; src_half = 8'h03;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reg;
        t_single;
        t_train;
        t_fixed;
        t_ext;
        finish_test;
    end
endmodule
`default_nettype wire
